// >>> agu_pkg.sv
package agu_pkg;
    localparam int AGU_AW = 16;
    localparam int AGU_DW = 8;
    localparam logic [15:0] AGU_PC_RESET = 16'h0000;
    localparam logic [15:0] AGU_SADDR_BASE = 16'hFE00;
    localparam logic [15:0] AGU_SFR_BASE = 16'hFF00;
    localparam logic [15:0] AGU_TABLE_BASE = 16'h0040;
    localparam logic [7:0] AGU_SADDR_SFR_TOP = 8'h1F;
    localparam logic [7:0] AGU_SADDR_RAM_LOW = 8'h80;
    localparam int AGU_BIT8_POS = 8;
    localparam int AGU_TIDX_LSB = 1;
    localparam int AGU_TIDX_MSB = 5;
    localparam int AGU_REG_CODE_W = 3;
    localparam int AGU_PAIR_CODE_W = 2;
    localparam logic [1:0] AGU_PAIR_ACC = 2'h0;

    typedef enum logic [2:0] {
        AGU_PC_SEQ = 3'b000,
        AGU_PC_REL = 3'b001,
        AGU_PC_IMM = 3'b010,
        AGU_PC_TBL = 3'b011,
        AGU_PC_ACC = 3'b100,
        AGU_PC_HOLD = 3'b101
    } agu_pc_op_t;

    typedef enum logic [1:0] {
        AGU_EA_DIRECT = 2'b00,
        AGU_EA_SHORT = 2'b01,
        AGU_EA_SFR = 2'b10
    } agu_ea_op_t;

    typedef enum logic [1:0] {
        AGU_TS_IDLE = 2'b00,
        AGU_TS_LOW = 2'b01,
        AGU_TS_HIGH = 2'b10
    } agu_tbl_state_t;
endpackage : agu_pkg

// >>> agu_gpr_if.sv
`timescale 1ns/1ns
interface agu_gpr_if;
    logic wr_en;
    logic [2:0] wr_sel;
    logic [7:0] wr_data;
    logic [2:0] rd_sel;
    logic [7:0] rd_data;
    logic [1:0] pair_sel;
    logic [15:0] pair_data;
    modport owner (output wr_en, wr_sel, wr_data, rd_sel, pair_sel, input rd_data, pair_data);
    modport bank (input wr_en, wr_sel, wr_data, rd_sel, pair_sel, output rd_data, pair_data);
endinterface : agu_gpr_if

// >>> agu_gpr_bank.sv
`timescale 1ns/1ns
module agu_gpr_bank
    import agu_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    agu_gpr_if.bank gpr
);
    logic [7:0] regs_reg [8];
    logic [7:0] regs_next [8];
    logic [7:0] rd_reg;
    logic [7:0] rd_next;
    logic [15:0] pair_reg;
    logic [15:0] pair_next;

    // pair n is registers 2n (low byte) and 2n+1 (high byte)
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            regs_next[i] = regs_reg[i];
        end
        if (gpr.wr_en) begin
            regs_next[gpr.wr_sel] = gpr.wr_data; // [RULE_12]
        end
        rd_next = regs_reg[gpr.rd_sel]; // [RULE_12] [RULE_13]
        pair_next = {regs_reg[{gpr.pair_sel, 1'b1}], regs_reg[{gpr.pair_sel, 1'b0}]}; // [RULE_13]
    end

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < 8; i++) begin
                regs_reg[i] <= 8'h00;
            end
            rd_reg <= 8'h00;
            pair_reg <= 16'h0000;
        end else begin
            regs_reg <= regs_next;
            rd_reg <= rd_next;
            pair_reg <= pair_next;
        end
    end

    assign gpr.rd_data = rd_reg;
    assign gpr.pair_data = pair_reg;
endmodule : agu_gpr_bank

// >>> agu_core.sv
`timescale 1ns/1ns
// Functional notes
// [RULE_01] sequential execution adds the fetched instruction length, one per byte, to the pc.
// [RULE_02] a relative branch adds the sign-extended 8-bit displacement to the next-instruction pc.
// [RULE_03] relative calculation serves the short unconditional branch and all conditional ones.
// [RULE_04] immediate call and branch load the 16-bit instruction address straight into the pc.
// [RULE_05] the table call uses opcode bits 1..5 to pick a word in 40H..7FH and jumps there.
// [RULE_06] the register-indirect branch copies the accumulator pair into the pc.
// [RULE_07] direct addressing uses the 16-bit immediate as the effective address.
// [RULE_08] short direct addressing maps the 8-bit operand into the window FE80H..FF1FH.
// [RULE_09] short direct clears address bit 8 for operands 80H..FFH and sets it for 00H..1FH.
// [RULE_10] sfr addressing places the 8-bit operand in FF00H..FFFFH.
// [RULE_11] FF00H..FF1FH are reached by short direct, not by sfr addressing.
// [RULE_12] a 3-bit code picks one of eight 8-bit general registers.
// [RULE_13] registers 0..7 form pairs 0..3, each selectable by absolute number.
// [RULE_14] a 16-bit short direct operand must sit at an even address.
// [RULE_15] short direct operands 20H..7FH clear bit 8, an assumption still to be confirmed.
module agu_core
    import agu_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic pc_step_in,
    input wire agu_pc_op_t pc_op_in,
    input wire logic [2:0] instr_len_in,
    input wire logic [7:0] rel_displacement_in,
    input wire logic [15:0] imm_addr_in,
    input wire logic [7:0] table_call_opcode_in,
    input wire logic [7:0] mem_rdata_in,
    input wire logic mem_rvalid_in,
    input wire logic ea_req_in,
    input wire agu_ea_op_t ea_op_in,
    input wire logic [7:0] ea_operand_in,
    input wire logic ea_word_in,
    input wire logic reg_wr_in,
    input wire logic [2:0] reg_wr_sel_in,
    input wire logic [7:0] reg_wr_data_in,
    input wire logic [2:0] reg_rd_sel_in,
    input wire logic [1:0] pair_rd_sel_in,
    output logic [15:0] pc_out,
    output logic pc_busy_out,
    output logic tbl_rd_out,
    output logic [15:0] tbl_addr_out,
    output logic [15:0] ea_out,
    output logic ea_valid_out,
    output logic ea_fault_out,
    output logic [7:0] reg_rdata_out,
    output logic [15:0] pair_rdata_out
);
    agu_gpr_if gpr ();

    agu_gpr_bank u_bank (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .gpr(gpr)
    );

    // accumulator pair is read through the shared pair port when branching through it
    logic [15:0] acc_pair;
    assign gpr.wr_en = reg_wr_in;
    assign gpr.wr_sel = reg_wr_sel_in;
    assign gpr.wr_data = reg_wr_data_in;
    assign gpr.rd_sel = reg_rd_sel_in;
    // the pair port is steered to the accumulator pair while its branch is pending
    logic acc_pending_reg;
    logic acc_pending_next;
    assign gpr.pair_sel = (acc_pending_reg || (pc_step_in && pc_op_in == AGU_PC_ACC))
        ? AGU_PAIR_ACC : pair_rd_sel_in;
    assign acc_pair = gpr.pair_data;
    assign reg_rdata_out = gpr.rd_data;
    assign pair_rdata_out = gpr.pair_data;

    function automatic logic [15:0] agu_short_ea(input logic [7:0] op);
        logic [15:0] ea;
        ea = {AGU_SADDR_BASE[15:9], 1'b0, op};
        if (op <= AGU_SADDR_SFR_TOP) begin
            ea[AGU_BIT8_POS] = 1'b1; // [RULE_09]
        end
        // 20H..7FH fall outside the documented window; bit 8 stays clear
        return ea; // [RULE_08] [RULE_15]
    endfunction : agu_short_ea

    function automatic logic [15:0] agu_sext8(input logic [7:0] d);
        return {{8{d[7]}}, d};
    endfunction : agu_sext8

    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    agu_tbl_state_t ts_reg;
    agu_tbl_state_t ts_next;
    logic [15:0] tbl_addr_reg;
    logic [15:0] tbl_addr_next;
    logic [7:0] tbl_low_reg;
    logic [7:0] tbl_low_next;
    logic [15:0] seq_pc;

    assign seq_pc = pc_reg + {13'h0000, instr_len_in}; // [RULE_01]

    always_comb begin
        pc_next = pc_reg;
        ts_next = ts_reg;
        tbl_addr_next = tbl_addr_reg;
        tbl_low_next = tbl_low_reg;
        acc_pending_next = 1'b0;
        unique case (ts_reg)
            AGU_TS_IDLE: begin
                if (acc_pending_reg) begin
                    pc_next = acc_pair; // [RULE_06]
                end else if (pc_step_in) begin
                    unique case (pc_op_in)
                        AGU_PC_SEQ: pc_next = seq_pc; // [RULE_01]
                        // conditional and short branches both land here
                        AGU_PC_REL: pc_next = seq_pc + agu_sext8(rel_displacement_in); // [RULE_02] [RULE_03]
                        AGU_PC_IMM: pc_next = imm_addr_in; // [RULE_04]
                        AGU_PC_TBL: begin
                            tbl_addr_next = AGU_TABLE_BASE
                                | {10'h000, table_call_opcode_in[AGU_TIDX_MSB:AGU_TIDX_LSB], 1'b0}; // [RULE_05]
                            ts_next = AGU_TS_LOW;
                        end
                        AGU_PC_ACC: acc_pending_next = 1'b1; // [RULE_06]
                        AGU_PC_HOLD: pc_next = pc_reg;
                        default: pc_next = pc_reg;
                    endcase
                end
            end
            AGU_TS_LOW: begin
                if (mem_rvalid_in) begin
                    tbl_low_next = mem_rdata_in;
                    tbl_addr_next = tbl_addr_reg + 16'h0001;
                    ts_next = AGU_TS_HIGH;
                end
            end
            AGU_TS_HIGH: begin
                if (mem_rvalid_in) begin
                    pc_next = {mem_rdata_in, tbl_low_reg}; // [RULE_05]
                    ts_next = AGU_TS_IDLE;
                end
            end
            default: ts_next = AGU_TS_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            pc_reg <= AGU_PC_RESET;
            ts_reg <= AGU_TS_IDLE;
            tbl_addr_reg <= 16'h0000;
            tbl_low_reg <= 8'h00;
            acc_pending_reg <= 1'b0;
        end else begin
            pc_reg <= pc_next;
            ts_reg <= ts_next;
            tbl_addr_reg <= tbl_addr_next;
            tbl_low_reg <= tbl_low_next;
            acc_pending_reg <= acc_pending_next;
        end
    end

    assign pc_out = pc_reg;
    assign pc_busy_out = (ts_reg != AGU_TS_IDLE) || acc_pending_reg;
    assign tbl_rd_out = (ts_reg != AGU_TS_IDLE);
    assign tbl_addr_out = tbl_addr_reg;

    logic [15:0] ea_reg;
    logic [15:0] ea_next;
    logic ea_valid_reg;
    logic ea_valid_next;
    logic ea_fault_reg;
    logic ea_fault_next;

    always_comb begin
        ea_next = ea_reg;
        ea_valid_next = 1'b0;
        ea_fault_next = 1'b0;
        if (ea_req_in) begin
            ea_valid_next = 1'b1;
            unique case (ea_op_in)
                AGU_EA_DIRECT: ea_next = {imm_addr_in[15:8], imm_addr_in[7:0]}; // [RULE_07]
                AGU_EA_SHORT: begin
                    ea_next = agu_short_ea(ea_operand_in); // [RULE_08] [RULE_09]
                    ea_fault_next = ea_word_in && ea_operand_in[0]; // [RULE_14]
                end
                AGU_EA_SFR: begin
                    ea_next = AGU_SFR_BASE | {8'h00, ea_operand_in}; // [RULE_10]
                    // the low 32 sfrs belong to the short direct path
                    ea_fault_next = (ea_operand_in <= AGU_SADDR_SFR_TOP); // [RULE_11]
                end
                default: begin
                    ea_next = ea_reg;
                    ea_fault_next = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            ea_reg <= 16'h0000;
            ea_valid_reg <= 1'b0;
            ea_fault_reg <= 1'b0;
        end else begin
            ea_reg <= ea_next;
            ea_valid_reg <= ea_valid_next;
            ea_fault_reg <= ea_fault_next;
        end
    end

    assign ea_out = ea_reg;
    assign ea_valid_out = ea_valid_reg;
    assign ea_fault_out = ea_fault_reg;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    AST_SEQ_PC: assert property (ts_reg == AGU_TS_IDLE && !acc_pending_reg && pc_step_in
        && pc_op_in == AGU_PC_SEQ |=> pc_out == $past(pc_out) + {13'h0000, $past(instr_len_in)}) // [RULE_01]
        else $error("sequential pc step wrong");
    AST_REL_PC: assert property (ts_reg == AGU_TS_IDLE && !acc_pending_reg && pc_step_in
        && pc_op_in == AGU_PC_REL |=> pc_out == $past(pc_out) + {13'h0000, $past(instr_len_in)}
        + {{8{$past(rel_displacement_in[7])}}, $past(rel_displacement_in)}) // [RULE_02]
        else $error("relative branch target wrong");
    AST_IMM_PC: assert property (ts_reg == AGU_TS_IDLE && !acc_pending_reg && pc_step_in
        && pc_op_in == AGU_PC_IMM |=> pc_out == $past(imm_addr_in)) // [RULE_04]
        else $error("immediate branch target wrong");
    AST_TBL_ADDR: assert property (ts_reg == AGU_TS_IDLE && !acc_pending_reg && pc_step_in
        && pc_op_in == AGU_PC_TBL |=> tbl_rd_out && tbl_addr_out >= 16'h0040
        && tbl_addr_out <= 16'h007E && !tbl_addr_out[0]) // [RULE_05]
        else $error("table entry address out of range");
    AST_ACC_PC: assert property (ts_reg == AGU_TS_IDLE && !acc_pending_reg && pc_step_in
        && pc_op_in == AGU_PC_ACC |=> ##1 pc_out == $past(pair_rdata_out)) // [RULE_06]
        else $error("accumulator pair branch wrong");
    // sfr results also land in FFxxH, so only a short direct request is judged here
    AST_SHORT_WIN: assert property (ea_valid_out && !ea_fault_out && $past(ea_op_in) == AGU_EA_SHORT
        |-> (ea_out[8] == (ea_out[7:0] <= 8'h1F))) // [RULE_09]
        else $error("short direct bit 8 wrong");
    AST_SHORT_EA: assert property (ea_req_in && ea_op_in == AGU_EA_SHORT && ea_operand_in >= 8'h80
        |=> ea_valid_out && ea_out == {8'hFE, $past(ea_operand_in)}) // [RULE_08]
        else $error("short direct ram address wrong");
    AST_SFR_EA: assert property (ea_req_in && ea_op_in == AGU_EA_SFR
        |=> ea_out == {8'hFF, $past(ea_operand_in)}
        && ea_fault_out == ($past(ea_operand_in) < 8'h20)) // [RULE_10] [RULE_11]
        else $error("sfr address or overlap flag wrong");
    AST_WORD_EVEN: assert property (ea_req_in && ea_op_in == AGU_EA_SHORT && ea_word_in
        |=> ea_fault_out == $past(ea_operand_in[0])) // [RULE_14]
        else $error("odd word short direct not flagged");

    COV_REL_BACK: cover property (pc_step_in && pc_op_in == AGU_PC_REL && rel_displacement_in[7]);
    COV_TBL_DONE: cover property (ts_reg == AGU_TS_HIGH && mem_rvalid_in);
    COV_SHORT_SFR: cover property (ea_req_in && ea_op_in == AGU_EA_SHORT && ea_operand_in < 8'h20);
endmodule : agu_core

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top
    import agu_pkg::*;
;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic pc_step_in = 1'b0;
    agu_pc_op_t pc_op_in = AGU_PC_HOLD;
    logic [2:0] instr_len_in = 3'h0;
    logic [7:0] rel_displacement_in = 8'h00;
    logic [15:0] imm_addr_in = 16'h0000;
    logic [7:0] table_call_opcode_in = 8'h00;
    logic [7:0] mem_rdata_in = 8'h00;
    logic mem_rvalid_in = 1'b0;
    logic ea_req_in = 1'b0;
    agu_ea_op_t ea_op_in = AGU_EA_DIRECT;
    logic [7:0] ea_operand_in = 8'h00;
    logic ea_word_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic [2:0] reg_wr_sel_in = 3'h0;
    logic [7:0] reg_wr_data_in = 8'h00;
    logic [2:0] reg_rd_sel_in = 3'h0;
    logic [1:0] pair_rd_sel_in = 2'h0;
    logic [15:0] pc_out;
    logic pc_busy_out;
    logic tbl_rd_out;
    logic [15:0] tbl_addr_out;
    logic [15:0] ea_out;
    logic ea_valid_out;
    logic ea_fault_out;
    logic [7:0] reg_rdata_out;
    logic [15:0] pair_rdata_out;
    int err_total = 0;
    int tests_run = 0;

    agu_core i_agu_core (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .pc_step_in(pc_step_in),
        .pc_op_in(pc_op_in), .instr_len_in(instr_len_in),
        .rel_displacement_in(rel_displacement_in), .imm_addr_in(imm_addr_in),
        .table_call_opcode_in(table_call_opcode_in), .mem_rdata_in(mem_rdata_in),
        .mem_rvalid_in(mem_rvalid_in), .ea_req_in(ea_req_in), .ea_op_in(ea_op_in),
        .ea_operand_in(ea_operand_in), .ea_word_in(ea_word_in), .reg_wr_in(reg_wr_in),
        .reg_wr_sel_in(reg_wr_sel_in), .reg_wr_data_in(reg_wr_data_in),
        .reg_rd_sel_in(reg_rd_sel_in), .pair_rd_sel_in(pair_rd_sel_in), .pc_out(pc_out),
        .pc_busy_out(pc_busy_out), .tbl_rd_out(tbl_rd_out), .tbl_addr_out(tbl_addr_out),
        .ea_out(ea_out), .ea_valid_out(ea_valid_out), .ea_fault_out(ea_fault_out),
        .reg_rdata_out(reg_rdata_out), .pair_rdata_out(pair_rdata_out));

    initial begin
        forever #10 mclk_in = ~mclk_in;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // every task starts and ends 1 ns after a rising edge
    task automatic tick;
        @(posedge mclk_in);
        #1;
    endtask : tick

    // one idle edge after each step, so a following step never re-raises the strobe at once
    task automatic pc_step(input agu_pc_op_t op);
        pc_op_in = op;
        pc_step_in = 1'b1;
        tick();
        pc_step_in = 1'b0;
        tick();
    endtask : pc_step

    task automatic wait_idle;
        for (int i = 0; i < 20 && pc_busy_out !== 1'b0; i++) begin
            tick();
        end
    endtask : wait_idle

    task automatic test_pc_flow;
        chk("pc after reset", 16'h0000, pc_out);
        instr_len_in = 3'h3;
        pc_op_in = AGU_PC_SEQ;
        pc_step_in = 1'b1;
        tick();
        instr_len_in = 3'h1;
        tick();
        pc_step_in = 1'b0;
        tick();
        chk("pc seq", 16'h0004, pc_out);
        imm_addr_in = 16'hC123;
        pc_step(AGU_PC_IMM);
        chk("pc imm", 16'hC123, pc_out);
        instr_len_in = 3'h2;
        rel_displacement_in = 8'h80;
        pc_step(AGU_PC_REL);
        chk("pc rel back", 16'hC0A5, pc_out);
        rel_displacement_in = 8'h7F;
        pc_step(AGU_PC_REL);
        chk("pc rel fwd", 16'hC126, pc_out);
        pc_step(AGU_PC_HOLD);
        chk("pc hold", 16'hC126, pc_out);
        $display("test pc_flow done");
    endtask : test_pc_flow

    task automatic test_table_call;
        table_call_opcode_in = 8'hBE;
        pc_step(AGU_PC_TBL);
        // a step while the table fetch is pending must be ignored
        pc_step(AGU_PC_IMM);
        for (int i = 0; i < 10 && tbl_rd_out !== 1'b1; i++) begin
            tick();
        end
        chk("table busy", 16'h0001, {15'h0000, pc_busy_out});
        chk("table low addr", 16'h007E, tbl_addr_out);
        mem_rdata_in = 8'h34;
        mem_rvalid_in = 1'b1;
        tick();
        mem_rvalid_in = 1'b0;
        mem_rdata_in = 8'hCB;
        tick();
        chk("table high addr", 16'h007F, tbl_addr_out);
        mem_rdata_in = 8'h12;
        mem_rvalid_in = 1'b1;
        tick();
        mem_rvalid_in = 1'b0;
        mem_rdata_in = 8'hED;
        tick();
        wait_idle();
        chk("pc table", 16'h1234, pc_out);
        chk("table read idle", 16'h0000, {15'h0000, tbl_rd_out});
        $display("test table_call done");
    endtask : test_table_call

    task automatic test_regs;
        logic [7:0] v;
        reg_rd_sel_in = 3'h5;
        tick();
        chk("reg reset", 16'h0000, {8'h00, reg_rdata_out});
        reg_wr_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            reg_wr_sel_in = 3'(i);
            reg_wr_data_in = 8'(8'h1B * i + 8'h05);
            tick();
        end
        reg_wr_in = 1'b0;
        for (int i = 0; i < 8; i++) begin
            v = 8'(8'h1B * i + 8'h05);
            reg_rd_sel_in = 3'(i);
            tick();
            chk("reg read", {8'h00, v}, {8'h00, reg_rdata_out});
        end
        for (int p = 0; p < 4; p++) begin
            pair_rd_sel_in = 2'(p);
            tick();
            chk("pair read", {8'(8'h1B * (2 * p + 1) + 8'h05), 8'(8'h1B * 2 * p + 8'h05)},
                pair_rdata_out);
        end
        pair_rd_sel_in = 2'h3;
        pc_step(AGU_PC_ACC);
        tick();
        wait_idle();
        chk("pc pair branch", 16'h2005, pc_out);
        $display("test regs done");
    endtask : test_regs

    // ea_req_in stays high across cases, so requests arrive back to back
    task automatic ea_case(input agu_ea_op_t op, input logic [7:0] opnd, input logic w);
        logic [15:0] e;
        logic f;
        ea_op_in = op;
        ea_operand_in = opnd;
        ea_word_in = w;
        ea_req_in = 1'b1;
        tick();
        e = (op == AGU_EA_DIRECT) ? imm_addr_in : (op == AGU_EA_SFR) ? {8'hFF, opnd} :
            {7'h7F, opnd <= 8'h1F, opnd};
        f = (op == AGU_EA_SHORT && w && opnd[0]) || (op == AGU_EA_SFR && opnd <= 8'h1F);
        chk("ea valid", 16'h0001, {15'h0000, ea_valid_out});
        chk("ea addr", e, ea_out);
        chk("ea fault", {15'h0000, f}, {15'h0000, ea_fault_out});
    endtask : ea_case

    task automatic test_ea;
        imm_addr_in = 16'hABCD;
        ea_case(AGU_EA_DIRECT, 8'h00, 1'b0);
        ea_case(AGU_EA_SHORT, 8'h80, 1'b0);
        ea_case(AGU_EA_SHORT, 8'hFF, 1'b0);
        ea_case(AGU_EA_SHORT, 8'h00, 1'b0);
        ea_case(AGU_EA_SHORT, 8'h1F, 1'b0);
        ea_case(AGU_EA_SHORT, 8'h20, 1'b0);
        ea_case(AGU_EA_SHORT, 8'h7F, 1'b0);
        ea_case(AGU_EA_SHORT, 8'h90, 1'b1);
        ea_case(AGU_EA_SHORT, 8'h91, 1'b1);
        ea_case(AGU_EA_SFR, 8'h20, 1'b0);
        ea_case(AGU_EA_SFR, 8'hFF, 1'b0);
        ea_case(AGU_EA_SFR, 8'h10, 1'b0);
        ea_req_in = 1'b0;
        tick();
        chk("ea valid drop", 16'h0000, {15'h0000, ea_valid_out});
        $display("test ea done");
    endtask : test_ea

    initial begin
        repeat (5) @(posedge mclk_in);
        #1;
        reset_n_in = 1'b1;
        test_pc_flow();
        test_table_call();
        test_regs();
        test_ea();
        print_verdict();
    end

    initial begin
        #200000;
        err_total++;
        $display("Error watchdog expected finish seen hang");
        print_verdict();
    end
endmodule : tb_top
